/* core/bhp_parser.sv */
`timescale 1ns/1ps
`default_nettype none
module bhp_parser #(
    parameter logic [15:0] SIG_VALUE = 16'hA55A // arbitrary value
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_start,
    input  wire logic        i_rd_valid,
    input  wire logic [7:0]  i_rd_data,
    input  wire logic        i_rd_nack,
    input  wire logic [7:0]  i_burst_len,
    output logic             o_rd_req,
    output logic      [15:0] o_rd_addr,
    output logic      [6:0]  o_dev_addr,
    output logic             o_busy,
    output logic             o_done,
    output logic             o_hdr_valid,
    output logic             o_hdr_invalid,
    output logic             o_no_eeprom,
    output logic      [7:0]  o_header_length,
    output logic      [15:0] o_maker_code,
    output logic      [15:0] o_part_code,
    output logic      [7:0]  o_part_revision,
    output logic      [7:0]  o_code_revision,
    output logic             o_strings_present,
    output logic             o_self_power_ok,
    output logic             o_bus_power_ok,
    output logic      [8:0]  o_supply_current_ma,
    output logic             o_cpu_clk_24m,
    output logic             o_header_overwrite,
    output logic             o_fast_bus_ok,
    output logic      [7:0]  o_write_burst_len,
    output logic             o_burst_ok,
    output logic             o_image_has_code,
    output logic             o_image_hdr_only
);
    import bhp_pkg::*;

    // ==============================
    // sequencer
    bhp_state_t state_reg;
    logic [7:0] idx_reg;
    logic [7:0] header_sum_byte_reg;
    logic [15:0] sig_reg;
    logic [7:0] bus_attr_byte_reg;
    logic [7:0] supply_current_steps_reg;
    logic [7:0] dev_attr_reg;
    logic [7:0] image_kind_reg;
    logic [7:0] sum_val;
    logic [7:0] end_idx;
    logic       take;
    logic       last;
    logic       sum_ok;
    logic       sig_ok;
    logic       kind_ok;
    logic       len_ok;
    logic       good;

    assign take    = (state_reg == BHP_WAIT) && i_rd_valid;
    // short length still reads every fixed field, then fails the header
    assign end_idx = (idx_reg > OFS_LENGTH && o_header_length > FIXED_LEN) ? o_header_length : FIXED_LEN;
    assign last    = (idx_reg + 8'h01) >= end_idx;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg <= BHP_IDLE;
        end else begin
            case (state_reg)
                BHP_IDLE: begin
                    if (i_start) begin
                        state_reg <= BHP_REQ;
                    end
                end
                BHP_REQ: begin
                    state_reg <= BHP_WAIT;
                end
                BHP_WAIT: begin
                    if (i_rd_nack || (take && last)) begin
                        state_reg <= BHP_DONE;
                    end else if (take) begin
                        state_reg <= BHP_REQ;
                    end
                end
                BHP_DONE: begin
                    state_reg <= BHP_IDLE;
                end
                default: begin
                    state_reg <= BHP_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            idx_reg <= 8'h00;
        end else if (state_reg == BHP_IDLE && i_start) begin
            idx_reg <= OFS_SUM_BYTE;
        end else if (take) begin
            idx_reg <= idx_reg + 8'h01;
        end
    end

    // ==============================
    // eeprom read requests
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rd_req   <= 1'b0;
            o_rd_addr  <= HDR_BASE_ADDR;
            o_dev_addr <= EE_DEV_ADDR;
        end else begin
            o_rd_req   <= (state_reg == BHP_REQ);
            o_rd_addr  <= HDR_BASE_ADDR + {8'h00, idx_reg};
            o_dev_addr <= EE_DEV_ADDR;
        end
    end

    // ==============================
    // field capture
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            header_sum_byte_reg      <= 8'h00;
            o_header_length          <= 8'h00;
            sig_reg                  <= 16'h0000;
            o_maker_code             <= 16'h0000;
            o_part_code              <= 16'h0000;
            o_part_revision          <= 8'h00;
            o_code_revision          <= 8'h00;
            bus_attr_byte_reg        <= 8'h00;
            supply_current_steps_reg <= 8'h00;
            dev_attr_reg             <= 8'h00;
            o_write_burst_len        <= 8'h00;
            image_kind_reg           <= 8'h00;
        end else if (take) begin
            case (idx_reg)
                OFS_SUM_BYTE: header_sum_byte_reg      <= i_rd_data;
                OFS_LENGTH:   o_header_length          <= i_rd_data;
                OFS_SIG_LO:   sig_reg[7:0]             <= i_rd_data;
                OFS_SIG_HI:   sig_reg[15:8]            <= i_rd_data;
                OFS_MAKER_LO: o_maker_code[7:0]        <= i_rd_data;
                OFS_MAKER_HI: o_maker_code[15:8]       <= i_rd_data;
                OFS_PART_LO:  o_part_code[7:0]         <= i_rd_data;
                OFS_PART_HI:  o_part_code[15:8]        <= i_rd_data;
                OFS_PART_REV: o_part_revision          <= i_rd_data;
                OFS_CODE_REV: o_code_revision          <= i_rd_data;
                OFS_BUS_ATTR: bus_attr_byte_reg        <= i_rd_data;
                OFS_SUPPLY:   supply_current_steps_reg <= i_rd_data;
                OFS_DEV_ATTR: dev_attr_reg             <= i_rd_data;
                OFS_BURST:    o_write_burst_len        <= i_rd_data;
                OFS_KIND:     image_kind_reg           <= i_rd_data;
                default: begin
                end
            endcase
        end
    end

    // ==============================
    // checksum over bytes one..length-1; string bytes are summed, not parsed
    bhp_sum_acc #(
        .W (8)
    ) u_sum (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_clr  (state_reg == BHP_IDLE && i_start),
        .i_en   (take && idx_reg != OFS_SUM_BYTE && (idx_reg < o_header_length || idx_reg == OFS_LENGTH)),
        .i_data (i_rd_data),
        .o_sum  (sum_val)
    );

    assign sum_ok  = (sum_val == header_sum_byte_reg);
    assign sig_ok  = (sig_reg == SIG_VALUE);
    assign kind_ok = (image_kind_reg == KIND_CODE) || (image_kind_reg == KIND_HDR_ONLY);
    assign len_ok  = (o_header_length >= FIXED_LEN);
    assign good    = sum_ok && sig_ok && kind_ok && len_ok && !o_no_eeprom;

    // ==============================
    // verdict and gated bits, held until the next start; other decoded settings held until the next done
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_done        <= 1'b0;
            o_busy        <= 1'b0;
            o_hdr_valid   <= 1'b0;
            o_hdr_invalid <= 1'b0;
        end else begin
            o_done <= (state_reg == BHP_DONE);
            o_busy <= (state_reg != BHP_IDLE) || i_start;
            if (state_reg == BHP_IDLE && i_start) begin
                o_hdr_valid   <= 1'b0;
                o_hdr_invalid <= 1'b0;
            end else if (state_reg == BHP_DONE) begin
                o_hdr_valid   <= good;
                o_hdr_invalid <= !good;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_no_eeprom <= 1'b0;
        end else if (state_reg == BHP_IDLE && i_start) begin
            o_no_eeprom <= 1'b0;
        end else if (state_reg == BHP_WAIT && i_rd_nack) begin
            o_no_eeprom <= 1'b1;
        end
    end

    // decoded bits only carry meaning while o_hdr_valid is high
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_strings_present   <= 1'b0;
            o_self_power_ok     <= 1'b0;
            o_bus_power_ok      <= 1'b0;
            o_supply_current_ma <= 9'h000;
            o_cpu_clk_24m       <= 1'b0;
            o_header_overwrite  <= 1'b0;
            o_fast_bus_ok       <= 1'b0;
            o_image_has_code    <= 1'b0;
            o_image_hdr_only    <= 1'b0;
        end else if (state_reg == BHP_IDLE && i_start) begin
            // gated bits follow the verdict, which drops at start
            o_fast_bus_ok       <= 1'b0;
            o_image_has_code    <= 1'b0;
            o_image_hdr_only    <= 1'b0;
        end else if (state_reg == BHP_DONE) begin
            o_strings_present   <= bus_attr_byte_reg[BUS_STRINGS_BIT];
            o_self_power_ok     <= bus_attr_byte_reg[BUS_SELF_BIT];
            o_bus_power_ok      <= bus_attr_byte_reg[BUS_BUSPWR_BIT];
            o_supply_current_ma <= {1'b0, supply_current_steps_reg} * {7'h00, SUPPLY_MA_STEP};
            o_cpu_clk_24m       <= dev_attr_reg[DEV_CLK24_BIT];
            o_header_overwrite  <= dev_attr_reg[DEV_OVWR_BIT];
            o_fast_bus_ok       <= good && dev_attr_reg[DEV_FAST_BIT];
            o_image_has_code    <= good && image_kind_reg == KIND_CODE;
            o_image_hdr_only    <= good && image_kind_reg == KIND_HDR_ONLY;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_burst_ok <= 1'b0;
        end else begin
            o_burst_ok <= o_hdr_valid && i_burst_len != 8'h00 && i_burst_len <= o_write_burst_len;
        end
    end

    // ==============================
    // checks
    a_dev_addr_fixed: assert property (@(posedge i_clk) disable iff (i_rst)
        $past(i_rst) == 1'b0 |-> o_dev_addr == 7'h50) else $error("eeprom address wrong");
    a_verdict_excl: assert property (@(posedge i_clk) disable iff (i_rst)
        !(o_hdr_valid && o_hdr_invalid)) else $error("valid and invalid together");
    a_done_verdict: assert property (@(posedge i_clk) disable iff (i_rst)
        o_done |-> (o_hdr_valid ^ o_hdr_invalid)) else $error("done without verdict");
    a_valid_sum: assert property (@(posedge i_clk) disable iff (i_rst)
        state_reg == BHP_DONE && !sum_ok |=> o_hdr_invalid) else $error("bad checksum accepted");
    a_kind_check: assert property (@(posedge i_clk) disable iff (i_rst)
        state_reg == BHP_DONE && image_kind_reg == 8'h03 |=> o_hdr_invalid && !o_image_has_code)
        else $error("bad image kind accepted");
    a_power_scale: assert property (@(posedge i_clk) disable iff (i_rst)
        state_reg == BHP_DONE |=> o_supply_current_ma == {$past(supply_current_steps_reg), 1'b0})
        else $error("supply current scaling wrong");
    a_fast_gate: assert property (@(posedge i_clk) disable iff (i_rst)
        o_fast_bus_ok |-> o_hdr_valid && dev_attr_reg[DEV_FAST_BIT]) else $error("fast bus without capability");
    a_req_addr: assert property (@(posedge i_clk) disable iff (i_rst)
        o_rd_req |-> o_rd_addr == {8'h00, idx_reg}) else $error("read address wrong");
    a_burst_limit: assert property (@(posedge i_clk) disable iff (i_rst)
        o_burst_ok |-> $past(i_burst_len) <= o_write_burst_len) else $error("burst over limit");
    a_clk_sel: assert property (@(posedge i_clk) disable iff (i_rst)
        state_reg == BHP_DONE ##1 1'b1 |-> o_cpu_clk_24m == $past(dev_attr_reg[DEV_CLK24_BIT]))
        else $error("clock select wrong");
    // a nack ends the parse two edges later with the failing verdict
    a_nack_invalid: assert property (@(posedge i_clk) disable iff (i_rst)
        state_reg == BHP_WAIT && i_rd_nack |=> ##1 o_hdr_invalid && o_no_eeprom && o_done)
        else $error("missing eeprom accepted");
    a_sig_check: assert property (@(posedge i_clk) disable iff (i_rst)
        state_reg == BHP_DONE && !sig_ok |=> o_hdr_invalid && !o_fast_bus_ok)
        else $error("bad signature accepted");
    a_code_gate: assert property (@(posedge i_clk) disable iff (i_rst)
        o_image_has_code || o_image_hdr_only |-> o_hdr_valid)
        else $error("image kind without valid header");
    a_strings_bit: assert property (@(posedge i_clk) disable iff (i_rst)
        state_reg == BHP_DONE |=> o_strings_present == $past(bus_attr_byte_reg[BUS_STRINGS_BIT]))
        else $error("strings flag wrong");
    a_busy_done: assert property (@(posedge i_clk) disable iff (i_rst)
        o_done |-> o_busy)
        else $error("done while not busy");
endmodule
`default_nettype wire

/* core/bhp_pkg.sv */
package bhp_pkg;
    // header layout, byte offsets from eeprom address zero
    localparam logic [7:0]  OFS_SUM_BYTE   = 8'h00;
    localparam logic [7:0]  OFS_LENGTH     = 8'h01;
    localparam logic [7:0]  OFS_SIG_LO     = 8'h02;
    localparam logic [7:0]  OFS_SIG_HI     = 8'h03;
    localparam logic [7:0]  OFS_MAKER_LO   = 8'h04;
    localparam logic [7:0]  OFS_MAKER_HI   = 8'h05;
    localparam logic [7:0]  OFS_PART_LO    = 8'h06;
    localparam logic [7:0]  OFS_PART_HI    = 8'h07;
    localparam logic [7:0]  OFS_PART_REV   = 8'h08;
    localparam logic [7:0]  OFS_CODE_REV   = 8'h09;
    localparam logic [7:0]  OFS_BUS_ATTR   = 8'h0A;
    localparam logic [7:0]  OFS_SUPPLY     = 8'h0B;
    localparam logic [7:0]  OFS_DEV_ATTR   = 8'h0C;
    localparam logic [7:0]  OFS_BURST      = 8'h0D;
    localparam logic [7:0]  OFS_KIND       = 8'h0E;
    localparam logic [7:0]  FIXED_LEN      = 8'h0F;
    localparam logic [15:0] HDR_BASE_ADDR  = 16'h0000;
    // field bit positions
    localparam int          BUS_STRINGS_BIT = 0;
    localparam int          BUS_SELF_BIT    = 2;
    localparam int          BUS_BUSPWR_BIT  = 3;
    localparam int          DEV_CLK24_BIT   = 0;
    localparam int          DEV_OVWR_BIT    = 1;
    localparam int          DEV_FAST_BIT    = 3;
    // image kinds
    localparam logic [7:0]  KIND_CODE      = 8'h01;
    localparam logic [7:0]  KIND_HDR_ONLY  = 8'h02;
    // eeprom bus address: control code and chip select
    localparam logic [3:0]  EE_CTRL_CODE   = 4'hA;
    localparam logic [2:0]  EE_CHIP_SEL    = 3'h0;
    localparam logic [6:0]  EE_DEV_ADDR    = {EE_CTRL_CODE, EE_CHIP_SEL};
    // current unit per step, in mA
    localparam logic [1:0]  SUPPLY_MA_STEP = 2'h2;
    typedef enum logic [1:0] {
        BHP_IDLE = 2'b00,
        BHP_REQ  = 2'b01,
        BHP_WAIT = 2'b11,
        BHP_DONE = 2'b10
    } bhp_state_t;
endpackage

/* core/bhp_sum_acc.sv */
`timescale 1ns/1ps
`default_nettype none
module bhp_sum_acc #(
    parameter int W = 8
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic         i_clr,
    input  wire logic         i_en,
    input  wire logic [W-1:0] i_data,
    output logic      [W-1:0] o_sum
);
    // carry out is dropped on purpose: only the low byte is kept
    always_ff @(posedge i_clk) begin
        if (i_rst || i_clr) begin
            o_sum <= '0;
        end else if (i_en) begin
            o_sum <= o_sum + i_data;
        end
    end
endmodule
`default_nettype wire

/* core/dummy_unused_none.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* verification/bhp_eeprom_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// eeprom model: one byte answered per request, after i_delay cycles
module bhp_eeprom_model (
    input  wire logic        i_clk,
    input  wire logic        i_rd_req,
    input  wire logic [15:0] i_rd_addr,
    input  wire logic [6:0]  i_dev_addr,
    input  wire logic        i_absent,
    input  wire logic [3:0]  i_delay,
    output var  logic        o_rd_valid,
    output var  logic [7:0]  o_rd_data,
    output var  logic        o_rd_nack
);
    logic [7:0] mem [0:31]; // header image starts at byte zero
    initial begin
        o_rd_valid = 1'b0;
        o_rd_nack  = 1'b0;
        o_rd_data  = 8'h00;
        forever begin
            @(negedge i_clk);
            if (i_rd_req === 1'b1) begin
                repeat (i_delay) @(negedge i_clk);
                // only 1010_000 is acknowledged
                if (i_absent || i_dev_addr !== 7'h50) o_rd_nack = 1'b1;
                else begin
                    o_rd_valid = 1'b1;
                    o_rd_data  = mem[i_rd_addr[4:0]];
                end
                @(negedge i_clk);
                o_rd_valid = 1'b0;
                o_rd_nack  = 1'b0;
                // released line must not look like a held byte
                o_rd_data  = ~o_rd_data;
            end
        end
    end
endmodule
`default_nettype wire

/* verification/bhp_parser_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// header parser bench
module bhp_parser_tb_top;
    import bhp_pkg::*;
    localparam logic [15:0] SIG = 16'hC3E1; // arbitrary value
    logic        clk, rst, start, absent, rd_req, rd_valid, rd_nack, busy, done, hv, hi, noee;
    logic        strs, selfp, busp, c24, ovw, fast, bok, hcode, honly;
    logic [7:0]  rd_data, blen, hlen, prev, crev, wbl;
    logic [15:0] rd_addr, maker, part;
    logic [6:0]  dev;
    logic [8:0]  ma;
    logic [3:0]  dly;
    logic [7:0]  img [0:31];
    logic [7:0]  bl [5] = '{8'h00, 8'h01, 8'h40, 8'h41, 8'hFF};
    logic        bx [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    logic [7:0]  kl [3] = '{8'h00, 8'h03, 8'hFF};
    int          failures = 0, samples_checked = 0, nrd = 0, cyc = 0;

    bhp_parser #(.SIG_VALUE(SIG)) bhp_parser_inst (.i_clk(clk), .i_rst(rst), .i_start(start),
        .i_rd_valid(rd_valid), .i_rd_data(rd_data), .i_rd_nack(rd_nack), .i_burst_len(blen),
        .o_rd_req(rd_req), .o_rd_addr(rd_addr), .o_dev_addr(dev), .o_busy(busy), .o_done(done),
        .o_hdr_valid(hv), .o_hdr_invalid(hi), .o_no_eeprom(noee), .o_header_length(hlen),
        .o_maker_code(maker), .o_part_code(part), .o_part_revision(prev), .o_code_revision(crev),
        .o_strings_present(strs), .o_self_power_ok(selfp), .o_bus_power_ok(busp),
        .o_supply_current_ma(ma), .o_cpu_clk_24m(c24), .o_header_overwrite(ovw),
        .o_fast_bus_ok(fast), .o_write_burst_len(wbl), .o_burst_ok(bok),
        .o_image_has_code(hcode), .o_image_hdr_only(honly));
    bhp_eeprom_model bhp_eeprom_model_inst (.i_clk(clk), .i_rd_req(rd_req), .i_rd_addr(rd_addr),
        .i_dev_addr(dev), .i_absent(absent), .i_delay(dly), .o_rd_valid(rd_valid),
        .o_rd_data(rd_data), .o_rd_nack(rd_nack));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // addresses must run 0,1,2,... one at a time
    always @(negedge clk) begin
        if (rd_req === 1'b1) begin
            check("rd_addr", rd_addr, 16'(nrd));
            nrd++;
        end
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            stop_test;
        end
    end

    task automatic one(input logic [7:0] kind, ba, da, len, input logic [15:0] sig,
                       input logic bad, input logic [3:0] d);
        logic [7:0] s;
        logic       ev;
        int         n;
        n = (len < 8'h0F) ? 15 : int'(len);
        for (int i = 0; i < 32; i++) img[i] = 8'(i * 7 + 3);
        img[OFS_LENGTH] = len;
        {img[OFS_SIG_HI], img[OFS_SIG_LO]} = sig;
        img[OFS_BUS_ATTR] = ba;
        img[OFS_SUPPLY] = 8'hFA;
        img[OFS_DEV_ATTR] = da;
        img[OFS_BURST] = 8'h40;
        img[OFS_KIND] = kind;
        {img[15], img[16], img[17], img[18]} = 32'h04030904;
        s = 8'h00;
        for (int i = 1; i < n; i++) s += img[i];
        img[OFS_SUM_BYTE] = bad ? ~s : s;
        ev = !bad && sig == SIG && (kind == KIND_CODE || kind == KIND_HDR_ONLY) && len >= 8'h0F && !absent;
        bhp_eeprom_model_inst.mem = img;
        dly = d;
        nrd = 0;
        @(negedge clk);
        start = 1'b1;
        // second cycle of start lands while busy and must be ignored
        repeat (2) @(negedge clk);
        check("busy_run", busy, 1);
        start = 1'b0;
        for (int i = 0; i < 400 && done !== 1'b1; i++) @(negedge clk);
        check("done", done, 1);
        check("valid", hv, ev);
        check("invalid", hi, !ev);
        check("no_eeprom", noee, absent);
        check("reads", 16'(nrd), 16'(absent ? 1 : n));
        if (!absent) begin
            check("length", hlen, len);
            check("maker", maker, {img[OFS_MAKER_HI], img[OFS_MAKER_LO]});
            check("part", part, {img[OFS_PART_HI], img[OFS_PART_LO]});
            check("revs", {prev, crev}, {img[OFS_PART_REV], img[OFS_CODE_REV]});
            check("strings", strs, ba[0]);
            check("self_pwr", selfp, ba[2]);
            check("bus_pwr", busp, ba[3]);
            check("supply", ma, 9'h1F4);
            check("clk24", c24, da[0]);
            check("overwrite", ovw, da[1]);
            check("fast", fast, ev & da[3]);
            check("wburst", wbl, 8'h40);
            check("code", hcode, ev & (kind == KIND_CODE));
            check("hdr_only", honly, ev & (kind == KIND_HDR_ONLY));
        end
        repeat (2) @(negedge clk);
        check("busy", busy, 0);
    endtask

    initial begin
        rst = 1'b1;
        start = 1'b0;
        absent = 1'b0;
        blen = 8'h00;
        dly = 4'h0;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        check("dev_addr", dev, 16'h0050);
        check("idle_valid", hv, 0);
        one(KIND_CODE, 8'h0C, 8'h0B, 8'h0F, SIG, 1'b0, 4'h0);
        for (int i = 0; i < 5; i++) begin
            blen = bl[i];
            repeat (2) @(negedge clk);
            check("burst_ok", bok, bx[i]);
        end
        one(KIND_HDR_ONLY, 8'h01, 8'h02, 8'h13, SIG, 1'b0, 4'h3);
        one(KIND_CODE, 8'h0C, 8'h0B, 8'h0F, SIG, 1'b1, 4'h1);
        one(KIND_CODE, 8'h0C, 8'h0B, 8'h0F, SIG ^ 16'h0100, 1'b0, 4'h0);
        one(KIND_CODE, 8'h0C, 8'h0B, 8'h0E, SIG, 1'b0, 4'h0);
        for (int i = 0; i < 3; i++) one(kl[i], 8'h08, 8'h09, 8'h0F, SIG, 1'b0, 4'h0);
        absent = 1'b1;
        one(KIND_CODE, 8'h0C, 8'h08, 8'h0F, SIG, 1'b0, 4'h2);
        stop_test;
    end
endmodule
`default_nettype wire
